// ### core/crfs_top.sv
// Overview of operation
// RQ1: Flags clear by writing one, condition gone.
// RQ2: Each flag has its own enable bit.
// RQ3: Init mode holds flags reset, ignores writes.
// RQ4: Writable again once init mode left.
// RQ5: Write one clears, zero ignored; read anytime.
// RQ6: State fields are read-only.
// RQ7: Wake flag on sleep activity when enabled.
// RQ8: Enabled wake flag raises wake-up request.
// RQ9: Status change flag on bus state change.
// RQ10: Change or overrun flag raises error request.
// RQ11: State fields frozen while change flag pending.
// RQ12: Receiver state coded by receive count.
// RQ13: State fields keep tracking during init.
// RQ14: Overrun flag set on data overrun.
// RQ15: Message flag set on good front-slot shift.
// RQ16: Software clears message flag releasing slot.
// RQ17: No front-slot shift while message flag set.
// RQ18: Enabled message flag raises receive request.
// RQ19: Bus-off shown in receiver field too.
// RQ20: Init active only when request and acknowledge.
// RQ21: Software reads buffer only with flag set.
// RQ22: Transmitter state coded by transmit count.
// RQ23: Reset clears flags, fields read normal.
//
// Chosen here: the address map and the plain strobed port.
module crfs_top
  import crfs_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rstn,
  // Register port
  input  wire crfs_bus_req_t  bus_req,
  output logic [CRFS_DW-1:0]  rdata,
  // Receive and error events
  input  wire crfs_rx_evt_t   rx_evt,
  // Front slot handshake
  output logic                front_shift,
  // Mode status
  output logic                init_acknowledge_bit,
  // Interrupt requests
  output logic                wakeup_irq,
  output logic                error_irq,
  output logic                receive_irq
);

  // ==========================================================================
  // Local state
  // ==========================================================================
  logic                 wakeup_flag;
  logic                 bus_state_change_flag;
  logic                 overrun_flag;
  logic                 message_waiting_flag;
  crfs_state_t          receiver_state_field;
  crfs_state_t          transmitter_state_field;
  logic [CRFS_DW-1:0]   receiver_irq_enable_register;
  logic                 init_request_bit;
  logic                 wakeup_enable_setting;
  logic                 sleep_activity_seen;
  crfs_state_t          live_rx;
  crfs_state_t          live_tx;
  logic                 init_active;
  logic                 flag_wr;
  logic [CRFS_DW-1:0]   clr;
  logic                 state_moved;
  logic                 shift_now;
  logic                 overrun_seen;
  logic [CRFS_DW-1:0]   next_rdata;

  // ==========================================================================
  // Counter classification
  // ==========================================================================
  crfs_state_decode u_decode (
    .transmit_error_count      (rx_evt.transmit_error_count),
    .inbound_error_tally      (rx_evt.inbound_error_tally),
    .rx_state (live_rx),
    .tx_state (live_tx)
  );

  // ==========================================================================
  // Mode and decode
  // ==========================================================================
  // Acknowledge follows the request one cycle later, so the mode is entered
  // and left as a handshake; both must be high for init to count as active.
  assign init_active = init_request_bit && init_acknowledge_bit;  // RQ20
  assign flag_wr     = bus_req.wr && (bus_req.addr == CRFS_ADDR_FLAG) && !init_active;  // RQ3 RQ4
  assign clr         = flag_wr ? bus_req.wdata : '0;  // RQ5
  assign state_moved = (live_rx != receiver_state_field) || (live_tx != transmitter_state_field);  // RQ9
  // A shift is offered only while the front slot is free.
  assign shift_now   = rx_evt.msg_ready && !message_waiting_flag && !init_active;  // RQ17 RQ15

  // Control register: init request and wake-up enable.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_request_bit      <= 1'b0;
      wakeup_enable_setting <= 1'b0;
    end else if (bus_req.wr && (bus_req.addr == CRFS_ADDR_CTRL)) begin
      init_request_bit      <= bus_req.wdata[CRFS_CTL_INIT];
      wakeup_enable_setting <= bus_req.wdata[CRFS_CTL_WAKE];
    end
  end

  // Acknowledge handshake; it drops only after the request has dropped.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_acknowledge_bit <= 1'b0;
    end else begin
      init_acknowledge_bit <= init_request_bit;  // RQ20
    end
  end

  // Interrupt enable register; held in reset during init mode like the flags.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      receiver_irq_enable_register <= CRFS_IRQEN_RESET;
    end else if (init_active) begin
      receiver_irq_enable_register <= CRFS_IRQEN_RESET;  // RQ2
    end else if (bus_req.wr && (bus_req.addr == CRFS_ADDR_IRQEN)) begin
      receiver_irq_enable_register <= bus_req.wdata;  // RQ2
    end
  end

  // ==========================================================================
  // Flags
  // ==========================================================================
  // Wake-up activity only counts while asleep with wake-up enabled.
  assign sleep_activity_seen = rx_evt.activity && rx_evt.sleeping && wakeup_enable_setting;
  assign overrun_seen        = rx_evt.overrun;

  // In the wake, overrun and message flags the set term wins over a same-cycle clear, which is how a
  // clear only takes effect once the setting condition has gone away.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakeup_flag <= 1'b0;  // RQ23
    end else if (init_active) begin
      wakeup_flag <= 1'b0;  // RQ3
    end else if (sleep_activity_seen) begin
      wakeup_flag <= 1'b1;  // RQ7
    end else if (clr[CRFS_BIT_WAKE]) begin
      wakeup_flag <= 1'b0;  // RQ1
    end
  end

  // Status change is raised when the live state differs from the frozen one.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_state_change_flag <= 1'b0;  // RQ23
    end else if (init_active) begin
      bus_state_change_flag <= 1'b0;  // RQ3
    end else if (state_moved && !bus_state_change_flag) begin
      bus_state_change_flag <= 1'b1;  // RQ9
    end else if (clr[CRFS_BIT_CHG]) begin
      bus_state_change_flag <= 1'b0;  // RQ1
    end
  end

  // Overrun flag.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overrun_flag <= 1'b0;  // RQ23
    end else if (init_active) begin
      overrun_flag <= 1'b0;  // RQ3
    end else if (overrun_seen) begin
      overrun_flag <= 1'b1;  // RQ14
    end else if (clr[CRFS_BIT_OVR]) begin
      overrun_flag <= 1'b0;  // RQ1
    end
  end

  // Message-waiting flag; clearing it frees the front slot for the next shift.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      message_waiting_flag <= 1'b0;  // RQ23
    end else if (init_active) begin
      message_waiting_flag <= 1'b0;  // RQ3
    end else if (shift_now) begin
      message_waiting_flag <= 1'b1;  // RQ15
    end else if (clr[CRFS_BIT_MSG]) begin
      message_waiting_flag <= 1'b0;  // RQ1 RQ16
    end
  end

  // Front-slot shift pulse towards the FIFO datapath.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      front_shift <= 1'b0;
    end else begin
      front_shift <= shift_now;  // RQ17
    end
  end

  // ==========================================================================
  // State fields
  // ==========================================================================
  // Fields ignore init mode and writes; they move only with no change pending,
  // so software always sees the state that raised the interrupt.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      receiver_state_field    <= CRFS_ST_NORMAL;  // RQ23
      transmitter_state_field <= CRFS_ST_NORMAL;  // RQ23
    end else if (!bus_state_change_flag) begin
      receiver_state_field    <= live_rx;  // RQ11 RQ13 RQ6
      transmitter_state_field <= live_tx;  // RQ11 RQ13 RQ6
    end
  end

  // ==========================================================================
  // Interrupt requests
  // ==========================================================================
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakeup_irq  <= 1'b0;
      error_irq   <= 1'b0;
      receive_irq <= 1'b0;
    end else begin
      wakeup_irq  <= wakeup_flag && receiver_irq_enable_register[CRFS_BIT_WAKE];  // RQ8
      error_irq   <= (bus_state_change_flag && receiver_irq_enable_register[CRFS_BIT_CHG])
                   || (overrun_flag && receiver_irq_enable_register[CRFS_BIT_OVR]);  // RQ10
      receive_irq <= message_waiting_flag && receiver_irq_enable_register[CRFS_BIT_MSG];  // RQ18
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Unmapped addresses read zero; the read is side-effect free.
  always_comb begin
    next_rdata = '0;
    case (bus_req.addr)
      CRFS_ADDR_FLAG: begin
        next_rdata[CRFS_BIT_WAKE]             = wakeup_flag;
        next_rdata[CRFS_BIT_CHG]              = bus_state_change_flag;
        next_rdata[CRFS_RST_HI:CRFS_RST_LO]   = receiver_state_field;
        next_rdata[CRFS_TST_HI:CRFS_TST_LO]   = transmitter_state_field;
        next_rdata[CRFS_BIT_OVR]              = overrun_flag;
        next_rdata[CRFS_BIT_MSG]              = message_waiting_flag;  // RQ5
      end
      CRFS_ADDR_IRQEN: begin
        next_rdata = receiver_irq_enable_register;
      end
      CRFS_ADDR_CTRL: begin
        next_rdata[CRFS_CTL_INIT] = init_request_bit;
        next_rdata[CRFS_CTL_WAKE] = wakeup_enable_setting;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

endmodule : crfs_top

// ### include/crfs_pkg.sv
package crfs_pkg;

  // ==========================================================================
  // Register map and field layout
  // ==========================================================================
  localparam logic [1:0] CRFS_ADDR_FLAG   = 2'h0;  // receiver_flag_register.
  localparam logic [1:0] CRFS_ADDR_IRQEN  = 2'h1;  // receiver_irq_enable_register.
  localparam logic [1:0] CRFS_ADDR_CTRL   = 2'h2;  // Initialization and wake-up control.
  localparam int         CRFS_AW          = 2;
  localparam int         CRFS_DW          = 8;

  localparam int CRFS_BIT_WAKE  = 7;
  localparam int CRFS_BIT_CHG   = 6;
  localparam int CRFS_BIT_OVR   = 1;
  localparam int CRFS_BIT_MSG   = 0;
  localparam int CRFS_RST_HI    = 5;
  localparam int CRFS_RST_LO    = 4;
  localparam int CRFS_TST_HI    = 3;
  localparam int CRFS_TST_LO    = 2;
  localparam int CRFS_CTL_INIT  = 0;
  localparam int CRFS_CTL_WAKE  = 1;

  localparam logic [7:0] CRFS_FLAG_RESET  = 8'h00;
  localparam logic [7:0] CRFS_IRQEN_RESET = 8'h00;
  localparam logic [7:0] CRFS_CTRL_RESET  = 8'h00;

  // ==========================================================================
  // Error count thresholds
  // ==========================================================================
  localparam logic [8:0] CRFS_WARN_LIMIT    = 9'h060;  // 96.
  localparam logic [8:0] CRFS_PASSIVE_LIMIT = 9'h07f;  // 127.
  localparam logic [8:0] CRFS_BUSOFF_LIMIT  = 9'h0ff;  // 255.

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    CRFS_ST_NORMAL  = 2'h0,
    CRFS_ST_WARNING = 2'h1,
    CRFS_ST_PASSIVE = 2'h2,
    CRFS_ST_BUSOFF  = 2'h3
  } crfs_state_t;

  typedef struct packed {
    logic [CRFS_AW-1:0] addr;
    logic [CRFS_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } crfs_bus_req_t;

  typedef struct packed {
    logic       activity;   // Bus activity, seen asleep or awake.
    logic       sleeping;   // Controller is in sleep mode.
    logic       overrun;    // Data overrun pulse.
    logic       msg_ready;  // Good message waits in the FIFO behind the front slot.
    logic [8:0] transmit_error_count;        // transmit_error_count.
    logic [8:0] inbound_error_tally;        // inbound_error_tally.
  } crfs_rx_evt_t;

endpackage : crfs_pkg

// ### core/crfs_state_decode.sv
// Classifies the two error counters into receiver and transmitter states.
module crfs_state_decode
  import crfs_pkg::*;
(
  // Counters
  input  wire logic [8:0] transmit_error_count,
  input  wire logic [8:0] inbound_error_tally,
  // Decoded states
  output crfs_state_t     rx_state,
  output crfs_state_t     tx_state
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Bus-off is a transmitter condition but overrides the receiver code too.
  always_comb begin
    if (transmit_error_count > CRFS_BUSOFF_LIMIT) begin
      rx_state = CRFS_ST_BUSOFF;  // RQ19
    end else if (inbound_error_tally > CRFS_PASSIVE_LIMIT) begin
      rx_state = CRFS_ST_PASSIVE;  // RQ12
    end else if (inbound_error_tally > CRFS_WARN_LIMIT) begin
      rx_state = CRFS_ST_WARNING;  // RQ12
    end else begin
      rx_state = CRFS_ST_NORMAL;  // RQ12
    end
  end

  // Transmitter coding mirrors the receiver with a bounded passive band.
  always_comb begin
    if (transmit_error_count > CRFS_BUSOFF_LIMIT) begin
      tx_state = CRFS_ST_BUSOFF;  // RQ22
    end else if (transmit_error_count > CRFS_PASSIVE_LIMIT) begin
      tx_state = CRFS_ST_PASSIVE;  // RQ22
    end else if (transmit_error_count > CRFS_WARN_LIMIT) begin
      tx_state = CRFS_ST_WARNING;  // RQ22
    end else begin
      tx_state = CRFS_ST_NORMAL;  // RQ22
    end
  end

endmodule : crfs_state_decode

// ### verification/crfs_top_props.sv
module crfs_top_props
  import crfs_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rstn,
  // Register port
  input wire crfs_bus_req_t      bus_req,
  input wire logic [CRFS_DW-1:0] rdata,
  // Events and handshake
  input wire crfs_rx_evt_t       rx_evt,
  input wire logic               front_shift,
  input wire logic               init_acknowledge_bit,
  // Interrupt requests
  input wire logic               wakeup_irq,
  input wire logic               error_irq,
  input wire logic               receive_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Shadow state rebuilt from bus writes
  // ==========================================================================
  logic       init_req;
  logic [7:0] ien;
  wire logic  init_act = init_req & init_acknowledge_bit;

  // The init request bit is only visible to us through control writes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) init_req <= 1'b0;
    else if (bus_req.wr && bus_req.addr == CRFS_ADDR_CTRL) init_req <= bus_req.wdata[CRFS_CTL_INIT];
  end

  // Enables are forced clear in init mode, so writes there are lost.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ien <= 8'h00;
    else if (init_act) ien <= 8'h00;
    else if (bus_req.wr && bus_req.addr == CRFS_ADDR_IRQEN) ien <= bus_req.wdata;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  rd_idle_a: assert property (!$past(bus_req.rd) |-> rdata == '0)
    else $error("read data not idle outside a read");
  shift_pulse_a: assert property (front_shift |=> !front_shift)
    else $error("front slot shifted twice in a row");
  shift_cause_a: assert property (front_shift |-> $past(rx_evt.msg_ready && !init_act))
    else $error("front slot shift without a ready message");
  init_ack_a: assert property (init_acknowledge_bit == $past(init_req))
    else $error("init acknowledge does not follow request");
  init_quiet_a: assert property (init_act [*3] |-> !(wakeup_irq || error_irq || receive_irq))
    else $error("interrupt request during init mode");
  wake_mask_a: assert property (wakeup_irq |-> $past(ien[7]))
    else $error("wake-up request while masked");
  err_mask_a: assert property (error_irq |-> $past(ien[6] || ien[1]))
    else $error("error request while masked");
  rx_mask_a: assert property (receive_irq |-> $past(ien[0]))
    else $error("receive request while masked");

  shift_c: cover property (front_shift);
  init_c: cover property (init_act [*3]);
  err_c: cover property (error_irq);
endmodule : crfs_top_props

bind crfs_top crfs_top_props u_props (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
  .rx_evt(rx_evt), .front_shift(front_shift), .init_acknowledge_bit(init_acknowledge_bit),
  .wakeup_irq(wakeup_irq), .error_irq(error_irq), .receive_irq(receive_irq));

// ### verification/crfs_can_peer.sv
module crfs_can_peer
  import crfs_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rstn,
  // Controller side
  input  wire logic    front_shift,
  output crfs_rx_evt_t rx_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  int offered = 0;
  int taken = 0;

  initial rx_evt = '0;

  // A shift is only seen one edge late, so ready may linger two cycles.
  always @(posedge clk or negedge rstn) begin
    // A reset drops whatever the FIFO still held, so nothing is offered after it.
    if (!rstn) taken <= offered;
    else if (front_shift) taken <= taken + 1;
  end
  always @(posedge clk) rx_evt.msg_ready <= offered > taken;

  task automatic offer(input int n);
    @(posedge clk);
    offered <= offered + n;
  endtask : offer
  task automatic counts(input logic [8:0] t, input logic [8:0] r);
    @(posedge clk);
    rx_evt.transmit_error_count <= t;
    rx_evt.inbound_error_tally <= r;
  endtask : counts
  task automatic ovr(input logic v);
    @(posedge clk);
    rx_evt.overrun <= v;
  endtask : ovr
  // One cycle of bus traffic, seen asleep or awake.
  task automatic wake(input logic s);
    @(posedge clk);
    rx_evt.sleeping <= s;
    rx_evt.activity <= 1'b1;
    @(posedge clk);
    rx_evt.sleeping <= 1'b0;
    rx_evt.activity <= 1'b0;
  endtask : wake
endmodule : crfs_can_peer

// ### verification/tb_can_receive_flag_status.sv
module tb_can_receive_flag_status;
  timeunit 1ns;
  timeprecision 1ps;
  import crfs_pkg::*;
  logic          clk, rstn, front_shift, init_acknowledge_bit;
  logic          wakeup_irq, error_irq, receive_irq, rd_seen;
  crfs_bus_req_t bus_req;
  crfs_rx_evt_t  rx_evt;
  logic [7:0]    rdata;
  logic [15:0]   exp_q[$];
  logic [15:0]   e_w;
  logic [31:0]   seed = 32'h4d6c6ee8;
  logic [8:0]    lv[7] = '{9'h000, 9'h060, 9'h061, 9'h07f, 9'h080, 9'h0ff, 9'h100};
  logic [8:0]    t, r;
  logic [3:0]    st, n;
  int            fail_count, check_count;

  crfs_top DUT (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .rx_evt(rx_evt),
    .front_shift(front_shift), .init_acknowledge_bit(init_acknowledge_bit),
    .wakeup_irq(wakeup_irq), .error_irq(error_irq), .receive_irq(receive_irq));
  crfs_can_peer peer (.clk(clk), .rstn(rstn), .front_shift(front_shift), .rx_evt(rx_evt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // Expected {receiver, transmitter} state from the two counts.
  function automatic logic [3:0] dec(input logic [8:0] tc, input logic [8:0] rc);
    logic [1:0] x, y;
    x = tc > 255 ? 2'h3 : rc > 127 ? 2'h2 : rc > 96 ? 2'h1 : 2'h0;
    y = tc > 255 ? 2'h3 : tc > 127 ? 2'h2 : tc > 96 ? 2'h1 : 2'h0;
    return {x, y};
  endfunction : dec
  task automatic cmp(input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask : cmp
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus_req <= '0;
  endtask : bus
  // The expectation is queued before the strobe goes out.
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask : idle
  // Irq outputs as {wake, error, receive}, sampled mid-cycle.
  task automatic irq(input logic [7:0] e);
    @(negedge clk);
    cmp(e, {5'h00, wakeup_irq, error_irq, receive_irq}, 8'h07);
  endtask : irq

  // Read data are checked in the one cycle where they stand.
  always @(posedge clk) rd_seen <= bus_req.rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) fail_count++;
      else begin
        e_w = exp_q.pop_front();
        cmp(e_w[7:0], rdata, e_w[15:8]);
      end
    end
  end

  // Hang guard; running out counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end

  initial begin
    bus_req = '0;
    rstn = 1'b0;
    rd_seen = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(CRFS_ADDR_FLAG, 8'h00, 8'hff);
    rd(2'h3, 8'h00, 8'hff);
    // Random reads and ignored writes while every register still holds reset.
    repeat (6) begin
      seed = xs(seed);
      if (seed[9]) rd(seed[1:0], 8'h00, 8'hff);
      else bus(1'b1, {2{seed[8]}}, seed[7:0]);
    end
    rd(CRFS_ADDR_FLAG, 8'h00, 8'hff);
    bus(1'b1, CRFS_ADDR_IRQEN, 8'hc3);
    // Two messages: the second must wait for the first release.
    peer.offer(2);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h01, 8'h01);
    irq(8'h01);
    bus(1'b1, CRFS_ADDR_FLAG, 8'hfe);
    rd(CRFS_ADDR_FLAG, 8'h01, 8'h01);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h01);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h01, 8'h01);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h01);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h00, 8'h01);
    // A clear while overrun still holds must not stick.
    peer.ovr(1'b1);
    idle(2);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h02);
    rd(CRFS_ADDR_FLAG, 8'h02, 8'h02);
    irq(8'h02);
    peer.ovr(1'b0);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h02);
    rd(CRFS_ADDR_FLAG, 8'h00, 8'h02);
    // Wake-up needs sleep, activity and the enable together.
    peer.wake(1'b1);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h00, 8'h80);
    bus(1'b1, CRFS_ADDR_CTRL, 8'h02);
    peer.wake(1'b0);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h00, 8'h80);
    peer.wake(1'b1);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h80, 8'h80);
    irq(8'h04);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h80);
    // Count boundaries for both fields, then random counts.
    st = 4'h0;
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      t = i < 7 ? lv[i] : i < 14 ? 9'h000 : seed[8:0];
      r = i < 7 ? 9'h000 : i < 14 ? lv[i-7] : seed[17:9];
      n = dec(t, r);
      peer.counts(t, r);
      idle(3);
      rd(CRFS_ADDR_FLAG, {1'b0, n != st, 6'h00}, 8'h40);
      bus(1'b1, CRFS_ADDR_FLAG, 8'h7c);
      idle(3);
      rd(CRFS_ADDR_FLAG, {2'h0, n, 2'h0}, 8'h7c);
      st = n;
    end
    peer.counts(9'h000, 9'h000);
    idle(3);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h40);
    // A second change while the flag is pending must leave the fields alone.
    peer.counts(9'h061, 9'h000);
    idle(3);
    peer.counts(9'h080, 9'h000);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h44, 8'h7c);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h40);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h48, 8'h7c);
    peer.counts(9'h000, 9'h000);
    idle(3);
    bus(1'b1, CRFS_ADDR_FLAG, 8'h40);
    // Init mode wipes flags but the fields keep tracking.
    peer.offer(1);
    idle(3);
    bus(1'b1, CRFS_ADDR_CTRL, 8'h01);
    peer.counts(9'h080, 9'h000);
    peer.offer(1);
    idle(4);
    rd(CRFS_ADDR_FLAG, 8'h08, 8'hff);
    irq(8'h00);
    bus(1'b1, CRFS_ADDR_CTRL, 8'h00);
    idle(3);
    rd(CRFS_ADDR_FLAG, 8'h09, 8'hff);
    irq(8'h00);
    bus(1'b1, CRFS_ADDR_IRQEN, 8'h01);
    idle(2);
    irq(8'h01);
    // A reset in mid-run must bring back the reset view of the register.
    peer.counts(9'h000, 9'h000);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(CRFS_ADDR_FLAG, 8'h00, 8'hff);
    irq(8'h00);
    final_report;
  end
endmodule : tb_can_receive_flag_status
